// file: shared/fsk_cd_pkg.sv
// Constants, register map and carrier types for the carrier-detect controller.
// Assumes a single 100 MHz clock domain and an Avalon-MM register slave.
package fsk_cd_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word addresses are byte offsets / 4)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] CTRL_OFS    = 10'h180;
  localparam logic [9:0] MODE_OFS    = 10'h181;
  localparam logic [9:0] STATUS_OFS  = 10'h183;
  localparam logic [9:0] FIFOCTL_OFS = 10'h18A;
  localparam logic [9:0] EHIGH_OFS   = 10'h18C;
  localparam logic [9:0] ELOW_OFS    = 10'h18D;
  localparam logic [9:0] FIFORD_OFS  = 10'h18E;

  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] MODE_RST    = 8'h04;
  localparam logic [7:0] FIFOCTL_RST = 8'h04;
  localparam logic [7:0] EHIGH_RST   = 8'h40;
  localparam logic [7:0] ELOW_RST    = 8'h20;

  // Control register field positions.
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_TYPE_BIT = 6;
  localparam int CTRL_MARK_BIT = 5;
  localparam int CTRL_INT_BIT  = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hE1;

  // Status register field positions.
  localparam int STAT_BIT_BIT  = 0;
  localparam int STAT_CDB_BIT  = 1;

  // Channel seizure bytes.
  localparam logic [7:0] SEIZE_A = 8'h55;
  localparam logic [7:0] SEIZE_B = 8'hAA;

  // Standard families encoded in the mode field, bit 3..2 give family.
  localparam logic [3:0] MODE_V23_LO = 4'h0;
  localparam logic [3:0] MODE_B202   = 4'h3;

  localparam int DATA_W = 8;

  typedef enum logic [1:0] {
    CD_IDLE  = 2'b00,
    CD_HUNT  = 2'b01,
    CD_ON    = 2'b10
  } cd_state_t;

  // Demodulator front-end indications, all on the system clock.
  typedef struct packed {
    logic       mark_tone;
    logic       space_tone;
    logic [7:0] energy;
    logic       rx_bit;
    logic       byte_valid;
    logic [7:0] byte_data;
  } demod_in_t;

  typedef struct packed {
    logic       enable;
    logic       type2;
    logic       mark_only;
    logic       pattern_irq;
    logic [3:0] mode;
    logic [7:0] e_high;
    logic [7:0] e_low;
  } cd_cfg_t;

endpackage

// file: src/fsk_carrier_sense.sv
// Carrier on/off decision for each standard family and session type.
// Assumes front-end indications arrive on clk; cfg is from the register file.
`timescale 1ns/100ps
module fsk_carrier_sense (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire fsk_cd_pkg::cd_cfg_t  cfg,
  input  wire fsk_cd_pkg::demod_in_t din,
  output logic                      carrier_q
);

  typedef struct packed {
    fsk_cd_pkg::cd_state_t st;
    logic                  carrier;
  } cs_state_t;

  cs_state_t s_q;
  cs_state_t s_d;
  logic      hi_speed;
  logic      tone_ok;
  logic      energy_on;
  logic      energy_off;
  logic      seize;

  // ---------------------------------------------------------------------------
  // Condition decode
  // ---------------------------------------------------------------------------
  always_comb
  begin
    hi_speed   = (cfg.mode <= fsk_cd_pkg::MODE_B202);
    energy_on  = (din.energy >= cfg.e_high);
    energy_off = (din.energy < cfg.e_low);
    seize      = din.byte_valid && (din.byte_data == fsk_cd_pkg::SEIZE_A ||
                 din.byte_data == fsk_cd_pkg::SEIZE_B);
    if (hi_speed && cfg.mark_only)
      tone_ok = din.mark_tone;
    else
      tone_ok = din.mark_tone || din.space_tone;
  end

  // ---------------------------------------------------------------------------
  // Carrier state machine
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      fsk_cd_pkg::CD_IDLE:
      begin
        s_d.carrier = 1'b0;
        if (cfg.enable)
          s_d.st = fsk_cd_pkg::CD_HUNT;
      end
      fsk_cd_pkg::CD_HUNT:
      begin
        if (!cfg.type2)
        begin
          // Type 1: seizure plus in-band evidence.
          if (seize && (hi_speed ? energy_on : tone_ok))
          begin
            s_d.st      = fsk_cd_pkg::CD_ON;
            s_d.carrier = 1'b1;
          end
        end
        else if (tone_ok)
        begin
          s_d.st      = fsk_cd_pkg::CD_ON;
          s_d.carrier = 1'b1;
        end
      end
      fsk_cd_pkg::CD_ON:
      begin
        if (hi_speed ? energy_off : !tone_ok)
        begin
          s_d.st      = fsk_cd_pkg::CD_HUNT;
          s_d.carrier = 1'b0;
        end
      end
      default:
        s_d = '{st: fsk_cd_pkg::CD_IDLE, carrier: 1'b0};
    endcase
    if (!cfg.enable)
      s_d = '{st: fsk_cd_pkg::CD_IDLE, carrier: 1'b0};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '{st: fsk_cd_pkg::CD_IDLE, carrier: 1'b0};
    else
      s_q <= s_d;
  end

  assign carrier_q = s_q.carrier;

endmodule // fsk_carrier_sense

// file: src/fsk_carrier_detect_ctrl.sv
// Control, carrier-detect and interrupt logic of the receive FSK detector.
// Assumes an Avalon-MM master on clk and a demodulator front end on clk.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module fsk_carrier_detect_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Avalon-MM slave, word addressed.
  input  wire logic [9:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  // Demodulator front end.
  input  wire fsk_cd_pkg::demod_in_t din,
  input  wire logic [3:0]            fifo_count,
  // Outputs.
  output logic                       fsk_irq,
  output logic                       decode_enable,
  output logic                       fifo_pop,
  output logic                       front_end_power
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  // The FIFO level arrives on four bits, so deeper FIFOs cannot be reported.
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 15)
  begin : g_depth_check
    $error("FIFO_DEPTH out of range");
  end

  // Every control field must sit inside the eight-bit register.
  if (fsk_cd_pkg::CTRL_EN_BIT >= fsk_cd_pkg::DATA_W || fsk_cd_pkg::CTRL_TYPE_BIT >= fsk_cd_pkg::DATA_W ||
      fsk_cd_pkg::CTRL_MARK_BIT >= fsk_cd_pkg::DATA_W || fsk_cd_pkg::CTRL_INT_BIT >= fsk_cd_pkg::DATA_W)
  begin : g_ctrl_check
    $error("control field outside the register");
  end

  // The two status fields must not overlap and must fit the register.
  if (fsk_cd_pkg::STAT_BIT_BIT >= fsk_cd_pkg::DATA_W || fsk_cd_pkg::STAT_CDB_BIT >= fsk_cd_pkg::DATA_W ||
      fsk_cd_pkg::STAT_BIT_BIT == fsk_cd_pkg::STAT_CDB_BIT)
  begin : g_stat_check
    $error("status fields overlap or lie outside the register");
  end

  // Carrier-off must sit below carrier-on, or the energy decision chatters.
  if (fsk_cd_pkg::ELOW_RST >= fsk_cd_pkg::EHIGH_RST)
  begin : g_energy_check
    $error("energy thresholds out of order at reset");
  end

  // The write mask must leave every control field writable.
  if (fsk_cd_pkg::CTRL_WMASK[fsk_cd_pkg::CTRL_EN_BIT] != 1'b1 ||
      fsk_cd_pkg::CTRL_WMASK[fsk_cd_pkg::CTRL_TYPE_BIT] != 1'b1 ||
      fsk_cd_pkg::CTRL_WMASK[fsk_cd_pkg::CTRL_MARK_BIT] != 1'b1 ||
      fsk_cd_pkg::CTRL_WMASK[fsk_cd_pkg::CTRL_INT_BIT] != 1'b1)
  begin : g_mask_check
    $error("control write mask hides a field");
  end

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  mode;
    logic [7:0]  fifoctl;
    logic [7:0]  e_high;
    logic [7:0]  e_low;
    logic        irq;
    logic        armed;
    logic        busy;
    logic [31:0] rdata;
    logic        decode;
    logic        pop;
    logic        power;
  } regs_t;

  regs_t                 r_q;
  regs_t                 r_d;
  fsk_cd_pkg::cd_cfg_t   cfg;
  logic                  carrier;
  logic [7:0]            status;
  logic                  seize;
  logic                  acc;
  logic                  wr_lo;
  logic                  rd_take;
  logic                  fifo_rd;
  logic                  wr_ctrl;
  logic                  wr_mode;
  logic                  wr_fifoctl;
  logic                  wr_ehigh;
  logic                  wr_elow;
  logic [7:0]            rd_word;
  logic                  pattern_hit;
  logic                  level_hit;
  logic                  irq_set;

  // ---------------------------------------------------------------------------
  // Carrier decision
  // ---------------------------------------------------------------------------
  always_comb
  begin
    cfg.enable      = r_q.ctrl[fsk_cd_pkg::CTRL_EN_BIT];
    cfg.type2       = r_q.ctrl[fsk_cd_pkg::CTRL_TYPE_BIT];
    cfg.mark_only   = r_q.ctrl[fsk_cd_pkg::CTRL_MARK_BIT];
    cfg.pattern_irq = r_q.ctrl[fsk_cd_pkg::CTRL_INT_BIT];
    cfg.mode        = r_q.mode[3:0];
    cfg.e_high      = r_q.e_high;
    cfg.e_low       = r_q.e_low;
  end

  fsk_carrier_sense u_sense (
    .clk       (clk),
    .nrst      (nrst),
    .cfg       (cfg),
    .din       (din),
    .carrier_q (carrier)
  );

  // ---------------------------------------------------------------------------
  // Status view
  // ---------------------------------------------------------------------------
  always_comb
  begin
    status = 8'h00;
    // Carrier-absent reads 1 until the carrier decision says otherwise.
    status[fsk_cd_pkg::STAT_CDB_BIT] = !carrier;
    // The live bit is masked while powered down so a dead front end is not seen.
    status[fsk_cd_pkg::STAT_BIT_BIT] = cfg.enable && din.rx_bit;
  end

  // ---------------------------------------------------------------------------
  // Channel seizure byte
  // ---------------------------------------------------------------------------
  always_comb
  begin
    seize = 1'b0;
    if (din.byte_valid)
    begin
      if (din.byte_data == fsk_cd_pkg::SEIZE_A)
        seize = 1'b1;
      if (din.byte_data == fsk_cd_pkg::SEIZE_B)
        seize = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // A request is taken while busy is low; a write lands one edge later, at the
  // edge where the master sees waitrequest low, so it lands exactly once.
  always_comb
  begin
    acc        = (read || write) && !r_q.busy;
    rd_take    = read && !r_q.busy;
    wr_lo      = write && r_q.busy && byteenable[0];
    fifo_rd    = rd_take && (address == fsk_cd_pkg::FIFORD_OFS);
    wr_ctrl    = wr_lo && (address == fsk_cd_pkg::CTRL_OFS);
    wr_mode    = wr_lo && (address == fsk_cd_pkg::MODE_OFS);
    wr_fifoctl = wr_lo && (address == fsk_cd_pkg::FIFOCTL_OFS);
    wr_ehigh   = wr_lo && (address == fsk_cd_pkg::EHIGH_OFS);
    wr_elow    = wr_lo && (address == fsk_cd_pkg::ELOW_OFS);
  end

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    case (address)
      fsk_cd_pkg::CTRL_OFS:    rd_word = r_q.ctrl;
      fsk_cd_pkg::MODE_OFS:    rd_word = r_q.mode;
      fsk_cd_pkg::STATUS_OFS:  rd_word = status;
      fsk_cd_pkg::FIFOCTL_OFS: rd_word = r_q.fifoctl;
      fsk_cd_pkg::EHIGH_OFS:   rd_word = r_q.e_high;
      fsk_cd_pkg::ELOW_OFS:    rd_word = r_q.e_low;
      fsk_cd_pkg::FIFORD_OFS:  rd_word = din.byte_data;
      default:                 rd_word = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Interrupt conditions
  // ---------------------------------------------------------------------------
  // Pattern mode ignores the FIFO level; normal mode waits for the level and
  // then stays quiet until the host has read the FIFO port once.
  always_comb
  begin
    pattern_hit = seize && carrier;
    level_hit   = r_q.armed && carrier && (fifo_count >= r_q.fifoctl[3:0]);
    if (cfg.pattern_irq)
      irq_set = pattern_hit;
    else
      irq_set = level_hit;
  end

  // ---------------------------------------------------------------------------
  // Register file and interrupt state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    r_d      = r_q;
    r_d.busy = acc;
    r_d.pop  = fifo_rd;
    if (wr_ctrl)
      r_d.ctrl = writedata[7:0] & fsk_cd_pkg::CTRL_WMASK;
    if (wr_mode)
      r_d.mode = writedata[7:0];
    if (wr_fifoctl)
      r_d.fifoctl = writedata[7:0];
    if (wr_ehigh)
      r_d.e_high = writedata[7:0];
    if (wr_elow)
      r_d.e_low = writedata[7:0];
    if (rd_take)
      r_d.rdata = {24'h000000, rd_word};
    // A FIFO read clears and rearms; a raise in the same cycle wins.
    if (fifo_rd)
    begin
      r_d.armed = 1'b1;
      r_d.irq   = 1'b0;
    end
    if (irq_set)
    begin
      r_d.irq = 1'b1;
      if (!cfg.pattern_irq)
        r_d.armed = 1'b0;
    end
    r_d.decode = cfg.enable && carrier;
    r_d.power  = cfg.enable;
    // Powering down drops the interrupt and leaves normal mode armed.
    if (!cfg.enable)
    begin
      r_d.irq   = 1'b0;
      r_d.armed = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_q         <= '0;
      r_q.ctrl    <= fsk_cd_pkg::CTRL_RST;
      r_q.mode    <= fsk_cd_pkg::MODE_RST;
      r_q.fifoctl <= fsk_cd_pkg::FIFOCTL_RST;
      r_q.e_high  <= fsk_cd_pkg::EHIGH_RST;
      r_q.e_low   <= fsk_cd_pkg::ELOW_RST;
      r_q.armed   <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Every output is a plain view of a state flop, except waitrequest, which is the inverse of busy.
  always_comb
  begin
    readdata        = r_q.rdata;
    waitrequest     = !r_q.busy;
    fsk_irq         = r_q.irq;
    decode_enable   = r_q.decode;
    fifo_pop        = r_q.pop;
    front_end_power = r_q.power;
  end

endmodule // fsk_carrier_detect_ctrl

// file: tb/fsk_cd_assertions.sv
// Checker for the carrier-detect controller, bound to its top ports.
// Assumes one clock domain and the register map of fsk_cd_pkg.
`timescale 1ns/100ps
module fsk_cd_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        fsk_irq,
  input wire logic        decode_enable,
  input wire logic        fifo_pop,
  input wire logic        front_end_power
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_fifo_read;
    read && address == fsk_cd_pkg::FIFORD_OFS;
  endsequence
  a_decode_needs_power: assert property (decode_enable |-> front_end_power || $past(front_end_power))
    else $error("decode active while powered down");
  a_irq_needs_power: assert property (fsk_irq |-> front_end_power || $past(front_end_power))
    else $error("interrupt active while powered down");
  a_irq_held_till_read: assert property ($fell(fsk_irq) |-> !front_end_power || fifo_pop || $past(fifo_pop))
    else $error("interrupt dropped without a FIFO read");
  a_pop_from_read: assert property (fifo_pop |-> $past(read) && $past(address) == fsk_cd_pkg::FIFORD_OFS)
    else $error("FIFO pop without a read of the FIFO port");
  a_pop_single: assert property (s_fifo_read ##1 fifo_pop |=> !fifo_pop)
    else $error("FIFO pop longer than one cycle");
  a_answer_soon: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("bus request not answered");
  a_wait_one_low: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (!waitrequest && read |-> readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule // fsk_cd_assertions

bind fsk_carrier_detect_ctrl fsk_cd_assertions u_chk (.clk(clk), .nrst(nrst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .fsk_irq(fsk_irq),
  .decode_enable(decode_enable), .fifo_pop(fifo_pop), .front_end_power(front_end_power));

// file: tb/fsk_front_end_model.sv
// Model of the demodulator front end that feeds tone, bit and byte events.
// Assumes the bench calls its tasks from a process synchronous to clk.
`timescale 1ns/100ps
module fsk_front_end_model (
  input wire logic                   clk,
  output     fsk_cd_pkg::demod_in_t  din
);
  initial din = '0;
  // A type 2 sender opens with a long mark and no seizure.
  task tone(input logic m);
    @(posedge clk);
    din.mark_tone <= m;
  endtask
  task space(input logic s);
    @(posedge clk);
    din.space_tone <= s;
  endtask
  task level(input logic [7:0] e);
    @(posedge clk);
    din.energy <= e;
  endtask
  task dbit(input logic b);
    @(posedge clk);
    din.rx_bit <= b;
  endtask
  // Byte data is inverted once the strobe ends so stale data never matches.
  task send(input logic [7:0] b);
    @(posedge clk);
    din.byte_valid <= 1'b1;
    din.byte_data  <= b;
    @(posedge clk);
    din.byte_valid <= 1'b0;
    din.byte_data  <= ~b;
  endtask
endmodule // fsk_front_end_model

// file: tb/fsk_carrier_detect_ctrl_test.sv
// Self-checking bench for the carrier-detect controller.
// Assumes the checker is bound and the front-end model drives din.
`timescale 1ns/100ps
module fsk_carrier_detect_ctrl_test;
  logic                  clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
  logic [9:0]            address = 10'h000;
  logic [31:0]           writedata = 32'h00000000, readdata, rd_q;
  logic                  waitrequest, fsk_irq, decode_enable, fifo_pop, front_end_power;
  logic [3:0]            fifo_count = 4'h0;
  logic [3:0]            byteenable = 4'hF;
  fsk_cd_pkg::demod_in_t din;
  int                    err_count = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  fsk_front_end_model u_fe (.clk(clk), .din(din));
  fsk_carrier_detect_ctrl u_dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .din(din), .fifo_count(fifo_count), .fsk_irq(fsk_irq),
    .decode_enable(decode_enable), .fifo_pop(fifo_pop), .front_end_power(front_end_power));
  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task ack;
    do @(posedge clk); while (waitrequest !== 1'b0);
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h000000, d};
    write     <= 1'b1;
    ack;
    write <= 1'b0;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task rc(input string n, input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    ack;
    rd_q = readdata;
    read <= 1'b0;
    chk(n, e, rd_q);
  endtask
  task settle;
    repeat (8) @(posedge clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up;
    end
  end
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rc("ctrl", fsk_cd_pkg::CTRL_OFS, 32'h00);
    rc("mode", fsk_cd_pkg::MODE_OFS, 32'h04);
    rc("status", fsk_cd_pkg::STATUS_OFS, 32'h02);
    rc("ehigh", fsk_cd_pkg::EHIGH_OFS, 32'h40);
    rc("elow", fsk_cd_pkg::ELOW_OFS, 32'h20);
    rc("unmapped", 10'h3FF, 32'h00);
    chk("power", 1'b0, front_end_power);
    $display("test reset done");
    byteenable <= 4'hE;
    wr(fsk_cd_pkg::CTRL_OFS, 8'hFF);
    byteenable <= 4'hF;
    rc("ctrl lane", fsk_cd_pkg::CTRL_OFS, 32'h00);
    wr(fsk_cd_pkg::CTRL_OFS, 8'hFF);
    rc("ctrl", fsk_cd_pkg::CTRL_OFS, 32'hE1);
    chk("power", 1'b1, front_end_power);
    wr(fsk_cd_pkg::CTRL_OFS, 8'hC0);
    settle;
    chk("decode", 1'b0, decode_enable);
    u_fe.tone(1'b1);
    for (int i = 0; i < 64 && decode_enable !== 1'b1; i++) @(posedge clk);
    chk("decode", 1'b1, decode_enable);
    u_fe.dbit(1'b1);
    settle;
    rc("status", fsk_cd_pkg::STATUS_OFS, 32'h01);
    u_fe.dbit(1'b0);
    settle;
    rc("status", fsk_cd_pkg::STATUS_OFS, 32'h00);
    $display("test carrier done");
    fifo_count <= 4'h3;
    settle;
    chk("irq", 1'b0, fsk_irq);
    fifo_count <= 4'h4;
    settle;
    chk("irq", 1'b1, fsk_irq);
    fifo_count <= 4'h0;
    settle;
    chk("irq", 1'b1, fsk_irq);
    rc("fifo", fsk_cd_pkg::FIFORD_OFS, 32'h00);
    settle;
    chk("irq", 1'b0, fsk_irq);
    $display("test normal irq done");
    wr(fsk_cd_pkg::CTRL_OFS, 8'hC1);
    u_fe.send(8'h12);
    settle;
    chk("irq", 1'b0, fsk_irq);
    u_fe.send(8'h55);
    settle;
    chk("irq", 1'b1, fsk_irq);
    rc("fifo", fsk_cd_pkg::FIFORD_OFS, {24'h000000, ~8'h55});
    settle;
    chk("irq", 1'b0, fsk_irq);
    u_fe.send(8'hAA);
    settle;
    chk("irq", 1'b1, fsk_irq);
    $display("test pattern irq done");
    wr(fsk_cd_pkg::CTRL_OFS, 8'h00);
    settle;
    chk("power", 1'b0, front_end_power);
    chk("decode", 1'b0, decode_enable);
    chk("irq", 1'b0, fsk_irq);
    rc("status", fsk_cd_pkg::STATUS_OFS, 32'h02);
    u_fe.tone(1'b0);
    $display("test disable done");
    wr(fsk_cd_pkg::MODE_OFS, 8'h03);
    wr(fsk_cd_pkg::CTRL_OFS, 8'h80);
    u_fe.level(8'h50);
    u_fe.send(8'h12);
    settle;
    chk("decode", 1'b0, decode_enable);
    u_fe.send(8'h55);
    settle;
    chk("decode", 1'b1, decode_enable);
    u_fe.level(8'h30);
    settle;
    chk("decode", 1'b1, decode_enable);
    u_fe.level(8'h10);
    settle;
    chk("decode", 1'b0, decode_enable);
    rc("status", fsk_cd_pkg::STATUS_OFS, 32'h02);
    wr(fsk_cd_pkg::CTRL_OFS, 8'hE0);
    u_fe.level(8'h50);
    u_fe.space(1'b1);
    settle;
    chk("decode", 1'b0, decode_enable);
    u_fe.tone(1'b1);
    settle;
    chk("decode", 1'b1, decode_enable);
    $display("test high speed done");
    wrap_up;
  end
endmodule // fsk_carrier_detect_ctrl_test
